// ---- verilog/serial_config_prom_readout.sv ----
// Purpose: read-out side of a serial configuration memory
// Assumes: array read has one clk of latency; bit clock comes from the loader
// Notes: fetch, cascade and pins on clk; bit shifting on serialBitClock
//
// Contract
// - cascade low once counter reaches maximum
// - paging makes bank top the maximum
// - bank code selects one quarter range
// - no paging: whole array, top is maximum
// - cascade low while selected and enabled
// - then cascade follows chip select
// - after enable low, cascade high until reread
// - cascade only in read-out mode
// - programming mode uses device select input
// - ready pulled low during power-up reset
// - serial enable low enters programming mode
// - enable low clears address and bit counters
// - selected and enabled: clock advances, data driven
// - chip select high stops counters, standby
// - programming mode ignores paging and bank

`timescale 1ns/1ps

module serial_config_prom_readout
    import prom_readout_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic srst,
    // loader pins
    input wire logic serialBitClock,
    input wire logic chipSelectN,
    input wire logic outputEnable,
    input wire logic serialEnableN,
    input wire logic pagingEnable,
    input wire logic [BANK_W-1:0] bankChoice,
    input wire logic programDeviceSelect,
    output logic dataOut,
    output logic dataOe,
    output logic cascadeOutN,
    output logic readyOut,
    output logic readyOe,
    // programming mode status
    output logic programResponds,
    // storage array
    output logic arrayRead,
    output logic [ADDR_W-1:0] arrayAddr,
    input wire logic [WORD_W-1:0] arrayData
);

    // ************************************
    // pin synchronisers
    // ************************************
    logic [PIN_W-1:0] pinMeta_q, pinSync_q;
    wire [PIN_W-1:0] pinRaw = {programDeviceSelect, bankChoice, pagingEnable,
                               serialEnableN, outputEnable, chipSelectN};

    always_ff @(posedge clk) begin
        pinMeta_q <= pinRaw;
        pinSync_q <= pinMeta_q;
    end

    wire csnSync = pinSync_q[PIN_CSN];
    wire oeSync = pinSync_q[PIN_OE];
    wire serEnSync = pinSync_q[PIN_SEREN];
    wire [BANK_W-1:0] bankSync = pinSync_q[PIN_BANK +: BANK_W];
    wire pageOn = serEnSync & pinSync_q[PIN_PAGE];
    wire progActive = ~serEnSync & pinSync_q[PIN_PSEL];

    // ************************************
    // power-up
    // ************************************
    logic [PWR_CNT_W-1:0] pwrCnt_q;
    logic readyOe_q, programResponds_q;
    wire pwrBusy = pwrCnt_q != PWR_DONE;

    always_ff @(posedge clk) begin
        if (srst) begin
            pwrCnt_q <= '0;
            readyOe_q <= 1'b1;
            programResponds_q <= 1'b0;
        end else begin
            if (pwrBusy) begin
                pwrCnt_q <= pwrCnt_q + 1'b1;
            end
            readyOe_q <= pwrBusy;
            programResponds_q <= progActive;
        end
    end

    assign readyOut = 1'b0;
    assign readyOe = readyOe_q;
    assign programResponds = programResponds_q;

    // ************************************
    // mode decode
    // ************************************
    // programming mode and a low enable both flush the read-out path
    wire flushNow = ~serEnSync | ~oeSync | pwrBusy;
    wire readRun = serEnSync & oeSync & ~csnSync & ~pwrBusy;
    wire [ADDR_W-1:0] baseNow = rangeBase(pageOn, bankSync);
    wire [ADDR_W-1:0] topNow = rangeTop(pageOn, bankSync);

    // ************************************
    // fetch counter and two-entry buffer
    // ************************************
    logic [ADDR_W-1:0] fetchAddr_q;
    logic fetchEnd_q, rdPend_q, rdLast_q;
    logic flushPrev_q, epoch_q;
    logic [WORD_W:0] buf_q [BUF_DEPTH];
    logic wrPtr_q, rdPtr_q;
    logic [1:0] bufCount_q;
    logic req_q;
    logic [WORD_W-1:0] sendData_q;
    logic sendLast_q, sendEpoch_q;
    logic [1:0] linkMeta_q, linkSync_q;
    logic doneLast_q;

    wire ackSync = linkSync_q[0];
    // reads are issued only while room is left for the word in flight
    wire [1:0] bufUsed = bufCount_q + {1'b0, rdPend_q};
    wire fetchGo = readRun & ~fetchEnd_q & (bufUsed < 2'(BUF_DEPTH));
    wire bufInValid = rdPend_q;
    wire bufInReady = bufCount_q != 2'(BUF_DEPTH);
    wire bufPush = bufInValid & bufInReady;
    wire bufOutValid = bufCount_q != 2'h0;
    wire bufOutReady = ~req_q & ~ackSync;
    wire bufPop = bufOutValid & bufOutReady;

    assign arrayRead = fetchGo;
    assign arrayAddr = fetchAddr_q;

    always_ff @(posedge clk) begin
        if (srst || flushNow) begin
            fetchAddr_q <= baseNow;
            fetchEnd_q <= 1'b0;
            rdPend_q <= 1'b0;
            rdLast_q <= 1'b0;
        end else begin
            rdPend_q <= fetchGo;
            rdLast_q <= fetchGo & (fetchAddr_q == topNow);
            if (fetchGo) begin
                fetchEnd_q <= fetchAddr_q == topNow;
                fetchAddr_q <= fetchAddr_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst || flushNow) begin
            wrPtr_q <= 1'b0;
            rdPtr_q <= 1'b0;
            bufCount_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_q ^ bufPush;
            rdPtr_q <= rdPtr_q ^ bufPop;
            bufCount_q <= bufCount_q + {1'b0, bufPush} - {1'b0, bufPop};
        end
    end

    always_ff @(posedge clk) begin
        if (bufPush) begin
            buf_q[wrPtr_q] <= {rdLast_q, arrayData};
        end
    end

    // ************************************
    // word handshake toward the bit clock
    // ************************************
    // a word sent before a flush carries the old epoch and is dropped by the link
    always_ff @(posedge clk) begin
        if (srst) begin
            flushPrev_q <= 1'b1;
            epoch_q <= 1'b0;
            req_q <= 1'b0;
            sendData_q <= '0;
            sendLast_q <= 1'b0;
            sendEpoch_q <= 1'b0;
        end else begin
            flushPrev_q <= flushNow;
            epoch_q <= epoch_q ^ (flushNow & ~flushPrev_q);
            if (bufPop) begin
                req_q <= 1'b1;
                {sendLast_q, sendData_q} <= buf_q[rdPtr_q];
                sendEpoch_q <= epoch_q;
            end else if (req_q && ackSync) begin
                req_q <= 1'b0;
            end
        end
    end

    // ************************************
    // cascade output
    // ************************************
    logic [1:0] linkTgl;
    logic linkRun_q, dataOe_q, cascadeOutN_q;
    casc_state_e cascState_q, cascState_d;
    // programming mode forces the cascade high without waiting for the state
    wire cascNext = ~serEnSync | ((cascState_q == CASC_FOLLOW) ? csnSync :
                                  (cascState_q != CASC_HOLD));

    always_ff @(posedge clk) begin
        linkMeta_q <= linkTgl;
        linkSync_q <= linkMeta_q;
        doneLast_q <= linkSync_q[1];
    end

    wire doneSeen = linkSync_q[1] ^ doneLast_q;

    always_comb begin
        cascState_d = cascState_q;
        unique case (cascState_q)
            CASC_IDLE: begin
                if (doneSeen && readRun) begin
                    cascState_d = CASC_HOLD;
                end
            end
            CASC_HOLD: begin
                if (csnSync) begin
                    cascState_d = CASC_FOLLOW;
                end
            end
            CASC_FOLLOW: begin
                cascState_d = CASC_FOLLOW;
            end
            default: begin
                cascState_d = CASC_IDLE;
            end
        endcase
        if (flushNow) begin
            cascState_d = CASC_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cascState_q <= CASC_IDLE;
            cascadeOutN_q <= 1'b1;
            dataOe_q <= 1'b0;
            linkRun_q <= 1'b0;
        end else begin
            cascState_q <= cascState_d;
            cascadeOutN_q <= cascNext;
            // the data driver lets go once this chip has handed over
            dataOe_q <= readRun & (cascState_q == CASC_IDLE);
            linkRun_q <= readRun;
        end
    end

    assign cascadeOutN = cascadeOutN_q;
    assign dataOe = dataOe_q;

    // ************************************
    // bit clock domain
    // ************************************
    logic lRstMeta_q, lRst_q;
    logic [2:0] lMeta_q, lSync_q;
    logic [WORD_W-1:0] shift_q;
    logic [BIT_CNT_W-1:0] bitCnt_q;
    logic haveWord_q, curLast_q, epochSeen_q;
    logic ack_q, doneTgl_q, dataOut_q;

    always_ff @(posedge serialBitClock) begin
        lRstMeta_q <= srst;
        lRst_q <= lRstMeta_q;
        lMeta_q <= {epoch_q, req_q, linkRun_q};
        lSync_q <= lMeta_q;
    end

    wire lRun = lSync_q[0];
    wire lReq = lSync_q[1];
    wire lEpoch = lSync_q[2];
    wire epochMove = lEpoch != epochSeen_q;
    wire stale = lReq & ~ack_q & (sendEpoch_q != lEpoch);
    wire useNew = lRun & ~haveWord_q & lReq & ~ack_q & ~stale & ~epochMove;
    wire shiftGo = lRun & ~epochMove & (haveWord_q | useNew);
    wire [WORD_W-1:0] curWord = useNew ? sendData_q : shift_q;
    wire lastNow = useNew ? sendLast_q : curLast_q;
    wire wordEnd = bitCnt_q == LAST_BIT;

    assign linkTgl = {doneTgl_q, ack_q};

    always_ff @(posedge serialBitClock) begin
        if (lRst_q) begin
            ack_q <= 1'b0;
            epochSeen_q <= 1'b0;
        end else begin
            epochSeen_q <= lEpoch;
            ack_q <= lReq & (ack_q | useNew | stale);
        end
    end

    always_ff @(posedge serialBitClock) begin
        if (lRst_q) begin
            shift_q <= '0;
            bitCnt_q <= '0;
            haveWord_q <= 1'b0;
            curLast_q <= 1'b0;
            doneTgl_q <= 1'b0;
            dataOut_q <= 1'b0;
        end else if (epochMove) begin
            bitCnt_q <= '0;
            haveWord_q <= 1'b0;
        end else if (shiftGo) begin
            dataOut_q <= curWord[0];
            shift_q <= curWord >> 1;
            bitCnt_q <= bitCnt_q + 1'b1;
            haveWord_q <= ~wordEnd;
            curLast_q <= lastNow;
            doneTgl_q <= doneTgl_q ^ (wordEnd & lastNow);
        end
    end

    assign dataOut = dataOut_q;

    // ************************************
    // checks
    // ************************************
    a_casc_assert: assert property (@(posedge clk) disable iff (srst)
        (doneSeen && readRun && cascState_q == CASC_IDLE) |-> ##2 !cascadeOutN_q)
        else $error("cascade not asserted after last bit");
    a_casc_hold_low: assert property (@(posedge clk) disable iff (srst)
        (cascState_q == CASC_HOLD && !csnSync && oeSync && serEnSync)
        |=> !cascadeOutN_q)
        else $error("cascade released while still selected");
    a_casc_follow_cs: assert property (@(posedge clk) disable iff (srst)
        (cascState_q == CASC_FOLLOW && serEnSync) |=> cascadeOutN_q == $past(csnSync))
        else $error("cascade not following chip select");
    a_casc_release: assert property (@(posedge clk) disable iff (srst)
        ($fell(oeSync) && cascState_q != CASC_IDLE) |-> ##2 cascadeOutN_q [*3])
        else $error("cascade low after enable dropped");
    a_casc_serial_off: assert property (@(posedge clk) disable iff (srst)
        !serEnSync |=> cascadeOutN_q && !dataOe_q)
        else $error("cascade or data active in programming mode");
    a_prog_select: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> programResponds_q == $past(progActive))
        else $error("device select not followed in programming mode");
    a_ready_powerup: assert property (@(posedge clk)
        $fell(srst) |-> readyOe_q [*8])
        else $error("ready released too early");
    a_fetch_range: assert property (@(posedge clk) disable iff (srst)
        arrayRead |-> (arrayAddr >= baseNow && arrayAddr <= topNow))
        else $error("fetch outside selected range");
    a_flush_counters: assert property (@(posedge clk) disable iff (srst)
        (serEnSync && !oeSync) |=> fetchAddr_q == $past(baseNow) && bufCount_q == 2'h0)
        else $error("enable low did not clear counters");
    a_standby_freeze: assert property (@(posedge clk) disable iff (srst)
        (csnSync && $past(csnSync) && oeSync) |-> $stable(fetchAddr_q))
        else $error("counter moved in standby");
    a_bit_count: assert property (@(posedge serialBitClock) disable iff (lRst_q)
        (shiftGo && wordEnd) |=> !haveWord_q && bitCnt_q == 4'h0)
        else $error("word not sixteen bits long");

    c_cascade_hold: cover property (@(posedge clk) disable iff (srst)
        cascState_q == CASC_HOLD);
    c_cascade_follow: cover property (@(posedge clk) disable iff (srst)
        cascState_q == CASC_FOLLOW ##1 !csnSync);
    c_top_bank_read: cover property (@(posedge clk) disable iff (srst)
        arrayRead && pageOn && bankSync == 2'h3);
    c_word_shifted: cover property (@(posedge serialBitClock) disable iff (lRst_q)
        useNew && shiftGo);

endmodule : serial_config_prom_readout

// ---- inc/prom_readout_pkg.sv ----
// Purpose: constants, state codes and range helpers of the prom read-out block
// Assumes: 1M words of 16 bits, 200 MHz system clock
// Notes: bank ranges are a quarter of the array each

package prom_readout_pkg;

    // ************************************
    // sizes
    // ************************************
    localparam int ADDR_W = 20;
    localparam int WORD_W = 16;
    localparam int BIT_CNT_W = 4;
    localparam int BANK_W = 2;
    localparam int BANK_LSB = 18;
    localparam int PIN_W = 7;
    localparam int BUF_DEPTH = 2;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hf;
    localparam logic [ADDR_W-1:0] ARRAY_BASE = 20'h00000;
    localparam logic [ADDR_W-1:0] ARRAY_TOP = 20'hfffff;
    localparam logic [BANK_LSB-1:0] BANK_LOW_TOP = 18'h3ffff;

    // ************************************
    // pin vector positions after the synchroniser
    // ************************************
    localparam int PIN_CSN = 0;
    localparam int PIN_OE = 1;
    localparam int PIN_SEREN = 2;
    localparam int PIN_PAGE = 3;
    localparam int PIN_BANK = 4;
    localparam int PIN_PSEL = 6;

    // ************************************
    // timing
    // ************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int POWERUP_NS = 1000;
    localparam int POWERUP_CYCLES = (POWERUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PWR_CNT_W = 8;
    localparam logic [PWR_CNT_W-1:0] PWR_DONE = PWR_CNT_W'(POWERUP_CYCLES);

    // ************************************
    // cascade state
    // ************************************
    typedef enum logic [2:0] {
        CASC_IDLE = 3'b001,
        CASC_HOLD = 3'b010,
        CASC_FOLLOW = 3'b100
    } casc_state_e;

    function automatic logic [ADDR_W-1:0] rangeBase(input logic paged,
                                                    input logic [BANK_W-1:0] bank);
        rangeBase = paged ? {bank, {BANK_LSB{1'b0}}} : ARRAY_BASE;
    endfunction : rangeBase

    function automatic logic [ADDR_W-1:0] rangeTop(input logic paged,
                                                   input logic [BANK_W-1:0] bank);
        rangeTop = paged ? {bank, BANK_LOW_TOP} : ARRAY_TOP;
    endfunction : rangeTop

endpackage : prom_readout_pkg

// ---- test/config_loader_model.sv ----
// Purpose: loader model that clocks bits out of the read-out block
// Assumes: first stored bit of every range is 1 and marks the start
// Notes: clock stands still low outside frames

`timescale 1ns/1ps

module config_loader_model (
    // control
    input wire logic run,
    // link
    output logic serialBitClock,
    input wire logic dataOut,
    input wire logic dataOe,
    // samples
    output logic gotBit,
    output logic gotVal
);
    logic started;

    // ************
    // bit clock
    // ************
    // 6 ns period, phase unrelated to clk
    initial begin
        serialBitClock = 1'b0;
        #1.7;
        forever begin
            #3;
            serialBitClock = run ? ~serialBitClock : 1'b0;
        end
    end

    // ************
    // sampling
    // ************
    // released line reads high through the pull-up
    wire line = (dataOe === 1'b1) ? dataOut : 1'b1;
    // the marker only counts while the block drives the line
    wire mark = (dataOe === 1'b1) && (line === 1'b1);

    // samples before this edge's own shift lands; a new frame hunts again
    always @(posedge serialBitClock or negedge run) begin
        if (!run) begin
            started <= 1'b0;
            gotBit <= 1'b0;
        end else begin
            started <= started || mark;
            gotBit <= started || mark;
            gotVal <= line;
        end
    end
endmodule : config_loader_model

// ---- test/test_serial_config_prom_readout.sv ----
// Purpose: self-checking bench of the prom read-out block
// Assumes: array model answers one clk after each read strobe
// Notes: full-range reads are too long, so the cascade end is not reached

`timescale 1ns/1ps

module test_serial_config_prom_readout
    import prom_readout_pkg::*;
;
    logic clk, srst, chipSelectN, outputEnable, serialEnableN, pagingEnable;
    logic [BANK_W-1:0] bankChoice;
    logic programDeviceSelect, run, serialBitClock, dataOut, dataOe;
    logic cascadeOutN, readyOut, readyOe, programResponds, arrayRead, gotBit, gotVal;
    logic [ADDR_W-1:0] arrayAddr;
    logic [WORD_W-1:0] arrayData, dataMask;
    logic [31:0] rng;
    logic [31:0] addrQ[$];
    logic bitQ[$];
    int err_total, check_count, readCount;

    serial_config_prom_readout dut_u (.clk(clk), .srst(srst),
        .serialBitClock(serialBitClock), .chipSelectN(chipSelectN),
        .outputEnable(outputEnable), .serialEnableN(serialEnableN),
        .pagingEnable(pagingEnable), .bankChoice(bankChoice),
        .programDeviceSelect(programDeviceSelect), .dataOut(dataOut), .dataOe(dataOe),
        .cascadeOutN(cascadeOutN), .readyOut(readyOut), .readyOe(readyOe),
        .programResponds(programResponds), .arrayRead(arrayRead),
        .arrayAddr(arrayAddr), .arrayData(arrayData));

    config_loader_model loader_u (.run(run), .serialBitClock(serialBitClock),
        .dataOut(dataOut), .dataOe(dataOe), .gotBit(gotBit), .gotVal(gotVal));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        lfsrNext = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsrNext

    // bit 0 forced high: the loader's start marker
    function automatic logic [WORD_W-1:0] wordAt(input logic [ADDR_W-1:0] a);
        wordAt = (a[WORD_W-1:0] ^ dataMask) | 16'h0001;
    endfunction : wordAt

    // ************
    // array model and monitors
    // ************
    // no read: data turns over so stale words never pass
    always @(posedge clk) begin
        if (arrayRead === 1'b1) begin
            arrayData <= wordAt(arrayAddr);
            readCount++;
            if (addrQ.size() > 0) check(32'(arrayAddr), addrQ.pop_front());
        end else begin
            arrayData <= ~arrayData;
        end
    end

    always @(posedge serialBitClock) begin
        if (gotBit === 1'b1 && bitQ.size() > 0) check(32'(gotVal), 32'(bitQ.pop_front()));
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic waitClk(input int n);
        repeat (n) @(negedge clk);
    endtask : waitClk

    // link clock runs during reset so the link side resets too
    task automatic doReset();
        chipSelectN = 1'b1;
        outputEnable = 1'b0;
        serialEnableN = 1'b1;
        srst = 1'b1;
        run = 1'b1;
        waitClk(12);
        srst = 1'b0;
        run = 1'b0;
        waitClk(190);
        check(32'(readyOe), 32'h1);
        check(32'(readyOut), 32'h0);
        waitClk(20);
        check(32'(readyOe), 32'h0);
    endtask : doReset

    task automatic runRange(input logic paged, input logic [BANK_W-1:0] bank);
        logic [ADDR_W-1:0] base;
        logic [WORD_W-1:0] w;
        int n;
        base = paged ? {bank, 18'h00000} : 20'h00000;
        rng = lfsrNext(rng);
        dataMask = rng[15:0];
        // range pins settle before the counters leave reset
        pagingEnable = paged;
        bankChoice = bank;
        doReset();
        serialEnableN = 1'b1;
        outputEnable = 1'b1;
        run = 1'b1;
        n = readCount;
        waitClk(40);
        check(32'(readCount), 32'(n));
        check(32'(dataOe), 32'h0);
        check(32'(cascadeOutN), 32'h1);
        run = 1'b0;
        waitClk(4);
        for (int i = 0; i < 6; i++) begin
            addrQ.push_back(32'(base) + 32'(i));
            w = wordAt(base + ADDR_W'(i));
            for (int b = 0; b < WORD_W && i < 4; b++) bitQ.push_back(w[b]);
        end
        chipSelectN = 1'b0;
        run = 1'b1;
        n = 0;
        while (n < 600 && (bitQ.size() > 0 || addrQ.size() > 0)) begin
            n++;
            waitClk(1);
        end
        check(32'(dataOe), 32'h1);
        check(32'(cascadeOutN), 32'h1);
        check(32'(bitQ.size()), 32'h0);
        check(32'(addrQ.size()), 32'h0);
        run = 1'b0;
    endtask : runRange

    task automatic test_done();
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // ************
    // main sequence
    // ************
    initial begin
        int n;
        srst = 1'b1;
        run = 1'b0;
        chipSelectN = 1'b1;
        outputEnable = 1'b0;
        serialEnableN = 1'b1;
        pagingEnable = 1'b0;
        bankChoice = 2'h0;
        programDeviceSelect = 1'b0;
        arrayData = 16'h0000;
        dataMask = 16'h0000;
        rng = 32'h9f44;
        err_total = 0;
        check_count = 0;
        readCount = 0;
        for (int b = 0; b < 4; b++) runRange(1'b1, BANK_W'(b));
        runRange(1'b0, rng[3:2]);
        // enable low must restart from the range base
        outputEnable = 1'b0;
        waitClk(10);
        addrQ.push_back(32'h0);
        addrQ.push_back(32'h1);
        outputEnable = 1'b1;
        run = 1'b1;
        waitClk(60);
        check(32'(addrQ.size()), 32'h0);
        run = 1'b0;
        // programming mode
        doReset();
        serialEnableN = 1'b0;
        chipSelectN = 1'b0;
        outputEnable = 1'b1;
        n = readCount;
        for (int i = 0; i < 8; i++) begin
            rng = lfsrNext(rng);
            programDeviceSelect = rng[0];
            pagingEnable = rng[1];
            bankChoice = rng[3:2];
            waitClk(6);
            check(32'(programResponds), 32'(rng[0]));
            check(32'(cascadeOutN), 32'h1);
            check(32'(dataOe), 32'h0);
        end
        check(32'(readCount), 32'(n));
        test_done();
    end

    // whole run takes about 11 us
    initial begin
        #100000;
        err_total++;
        test_done();
    end
endmodule : test_serial_config_prom_readout
